// *** rtl/sfspi_regs.svh ***
// constants for the serial flash front end: status layout, opcodes, host map, timing
`ifndef SFSPI_REGS_SVH
`define SFSPI_REGS_SVH

`define SFSPI_ST_BUSY 0
`define SFSPI_ST_WEL 1
`define SFSPI_ST_LVL_LO 2
`define SFSPI_ST_LVL_HI 5
`define SFSPI_ST_AAI 6
`define SFSPI_ST_LOCK 7
`define SFSPI_LVL_RESET 4'h7
`define SFSPI_BYTE_LAST 3'h7

`define SFSPI_OP_WRITE_STATUS_CMD 8'h01
`define SFSPI_OP_WRDI 8'h04
`define SFSPI_OP_RDSR 8'h05
`define SFSPI_OP_WREN 8'h06
`define SFSPI_OP_SE4K 8'h20
`define SFSPI_OP_BE32K 8'h52
`define SFSPI_OP_BE64K 8'hd8
`define SFSPI_OP_EBSY 8'h70
`define SFSPI_OP_DBSY 8'h80

`define SFSPI_SECTOR_BYTES 4096
`define SFSPI_BLOCK32_BYTES 32768
`define SFSPI_BLOCK64_BYTES 65536

`define SFSPI_ADR_CTRL 4'h0
`define SFSPI_ADR_TX 4'h4
`define SFSPI_ADR_RX 4'h8
`define SFSPI_ADR_STAT 4'hc
`define SFSPI_CTRL_MODE3 0
`define SFSPI_CTRL_HOLD 1
`define SFSPI_CTRL_WP 2
`define SFSPI_CTRL_KEEP 3
`define SFSPI_CTRL_RESET 4'h4

`define SFSPI_CLK_NS 20
`define SFSPI_SCK_NS 160
`define SFSPI_HALF_CYC (`SFSPI_SCK_NS / (2 * `SFSPI_CLK_NS))

`endif

// *** rtl/sfspi_pkg.sv ***
// types shared by both ends of the serial flash link
package sfspi_pkg;

	typedef enum logic [0:0] {
		SFSPI_PH_OPC = 1'b0,
		SFSPI_PH_DAT = 1'b1
	} sfspi_phase_t;

	typedef enum logic [1:0] {
		SFSPI_H_IDLE = 2'b00,
		SFSPI_H_LOW = 2'b01,
		SFSPI_H_HIGH = 2'b10
	} sfspi_hstate_t;

	typedef enum logic [1:0] {
		SFSPI_ER_NONE = 2'b00,
		SFSPI_ER_4K = 2'b01,
		SFSPI_ER_32K = 2'b10,
		SFSPI_ER_64K = 2'b11
	} sfspi_erase_t;

	typedef struct packed {
		logic sck_q;
		logic paused;
		sfspi_phase_t phase;
		logic [2:0] bit_cnt;
		logic [7:0] rx_sh;
		logic [7:0] cmd;
		logic write_enable_flag;
		logic lock;
		logic [3:0] level;
		logic ebsy;
		logic tx_on;
		logic [7:0] tx_sh;
		logic [2:0] tx_cnt;
		logic so;
		logic so_oe_n;
		logic [7:0] status;
		logic [7:0] cmd_byte;
		logic cmd_valid;
		logic [7:0] data_byte;
		logic data_valid;
		sfspi_erase_t erase_kind;
	} sfspi_dev_t;

	typedef struct packed {
		sfspi_hstate_t st;
		logic [3:0] div;
		logic [2:0] bitn;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [3:0] ctrl;
		logic done;
		logic cs_n;
		logic sck;
		logic si;
		logic [7:0] rdata;
	} sfspi_host_t;

endpackage

// *** rtl/sfspi_if.sv ***
// link between the flash front end and its host controller
`timescale 1ns/1ps
interface sfspi_if;
	logic sck;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe_n;
	logic hold_n;
	logic wp_n;
	logic so_line;

	// pull-up stands in for the floating output line
	assign so_line = so_oe_n ? 1'b1 : so;

	modport dev (
		input sck,
		input cs_n,
		input si,
		input hold_n,
		input wp_n,
		output so,
		output so_oe_n
	);

	modport host (
		output sck,
		output cs_n,
		output si,
		output hold_n,
		output wp_n,
		input so_line
	);
endinterface

// *** rtl/sfspi_sync.sv ***
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sfspi_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	input wire logic [W-1:0] init,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sfspi_sync_t;

	sfspi_sync_t r_reg;
	sfspi_sync_t r_next;

	always_comb begin
		r_next.s1 = d ^ init;
		r_next.s2 = r_reg.s1;
	end

	// init is a tie-off constant at every instance, so reset stays a constant load
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign q = r_reg.s2 ^ init;
endmodule

// *** rtl/sfspi_device.sv ***
// flash-side serial front end: framing, hold, status register, byte stream
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "sfspi_regs.svh"
// Notes on behaviour
// RULE_01 - sample input on rise, drive output after fall
// RULE_02 - only modes (0,0) and (1,1) supported
// RULE_03 - chip select low frames every command
// RULE_04 - host pauses only while chip selected (code: host hold follows the control bit alone, also while deselected)
// RULE_05 - pause input falling with clock low pauses
// RULE_06 - pause input rising with clock low resumes
// RULE_07 - edges during clock high wait for low
// RULE_08 - paused: output floats, clock and input ignored
// RULE_09 - pause keeps bit position in the sequence
// RULE_10 - deselect during pause resets, pause persists
// RULE_11 - resume needs pause high and select low
// RULE_12 - status write refused only when protect low, locked
// RULE_13 - host only reads status while busy
// RULE_14 - bit 0 busy, read-only, zero at power-up
// RULE_15 - bit 1 write-enable flag, read-only, starts zero
// RULE_16 - bits 2-4 protection level, writable, start one (code: level spans bits 2-5, bit 5 also writable, starts zero)
// RULE_17 - erase in sectors and two block sizes
// RULE_18 - output may show ready/busy in auto-increment mode
// RULE_19 - locked with protect low freezes protection bits
// RULE_20 - bit 6 auto-increment flag, read-only, starts zero
// RULE_21 - write-enable clears on completed write operations
// RULE_22 - bytes of eight bits, most significant first
module sfspi_device
	import sfspi_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	sfspi_if.dev link,
	input wire logic array_busy,
	input wire logic aai_mode,
	input wire logic write_done,
	output logic [7:0] status_out,
	output logic [7:0] cmd_byte,
	output logic cmd_valid,
	output logic [7:0] data_byte,
	output logic data_valid,
	output sfspi_pkg::sfspi_erase_t erase_kind
);
	import sfspi_pkg::*;

	sfspi_dev_t r_reg;
	sfspi_dev_t r_next;
	logic [4:0] pins_s;
	logic s_sck;
	logic s_cs_n;
	logic s_si;
	logic s_hold_n;
	logic s_wp_n;
	logic sck_rise;
	logic sck_fall;
	logic [7:0] rx;
	logic [7:0] st_now;
	logic [7:0] wr_mask;

	// active-low pins are inverted around the flops so they come out of reset high
	sfspi_sync #(.W(5)) u_sync (
		.clk(clk),
		.rstn(rstn),
		.d({link.sck, link.cs_n, link.si, link.hold_n, link.wp_n}),
		.init(5'h0b),
		.q(pins_s)
	);

	assign {s_sck, s_cs_n, s_si, s_hold_n, s_wp_n} = pins_s;
	assign sck_rise = s_sck & ~r_reg.sck_q;
	assign sck_fall = ~s_sck & r_reg.sck_q;
	assign rx = {r_reg.rx_sh[6:0], s_si}; // see RULE_22

	always_comb begin
		r_next = r_reg;
		r_next.cmd_valid = 1'b0;
		r_next.data_valid = 1'b0;
		r_next.sck_q = s_sck;
		st_now = {r_reg.lock, aai_mode, r_reg.level, r_reg.write_enable_flag, array_busy}; // see RULE_14
		wr_mask = 8'hbc;
		// program, erase and auto-increment completion reported by the array
		if (write_done) begin
			r_next.write_enable_flag = 1'b0; // see RULE_21
		end
		if (!s_cs_n) begin
			// pause changes only take effect while the clock is low
			if (!s_sck) begin
				r_next.paused = ~s_hold_n; // see RULE_05 // see RULE_06 // see RULE_07
			end
		end else begin
			// deselect alone cannot start a pause, only prolong one
			r_next.paused = r_reg.paused & ~s_hold_n; // see RULE_10 // see RULE_11
		end
		if (s_cs_n) begin
			r_next.phase = SFSPI_PH_OPC; // see RULE_03
			r_next.bit_cnt = 3'h0;
			r_next.tx_on = 1'b0;
		end else if (!r_reg.paused) begin
			// clock edges are dropped while paused, counters hold their place
			if (sck_rise) begin
				r_next.rx_sh = rx; // see RULE_01 // see RULE_09
				r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
				if (r_reg.bit_cnt == `SFSPI_BYTE_LAST) begin
					if (r_reg.phase == SFSPI_PH_OPC) begin
						r_next.phase = SFSPI_PH_DAT;
						r_next.cmd = rx;
						r_next.cmd_byte = rx;
						r_next.cmd_valid = 1'b1;
						if (rx == `SFSPI_OP_RDSR) begin
							r_next.tx_on = 1'b1;
							r_next.tx_sh = st_now;
							r_next.tx_cnt = 3'h0;
						end else if (array_busy) begin
							// only status reads are honoured during an internal write
							r_next.cmd = 8'h00; // see RULE_13
						end else if (rx == `SFSPI_OP_WREN) begin
							r_next.write_enable_flag = 1'b1;
						end else if (rx == `SFSPI_OP_WRDI) begin
							r_next.write_enable_flag = 1'b0; // see RULE_21
						end else if (rx == `SFSPI_OP_EBSY) begin
							r_next.ebsy = 1'b1; // see RULE_18
						end else if (rx == `SFSPI_OP_DBSY) begin
							r_next.ebsy = 1'b0;
						end else if (rx == `SFSPI_OP_SE4K && r_reg.write_enable_flag) begin
							r_next.erase_kind = SFSPI_ER_4K; // see RULE_17
						end else if (rx == `SFSPI_OP_BE32K && r_reg.write_enable_flag) begin
							r_next.erase_kind = SFSPI_ER_32K; // see RULE_17
						end else if (rx == `SFSPI_OP_BE64K && r_reg.write_enable_flag) begin
							r_next.erase_kind = SFSPI_ER_64K; // see RULE_17
						end
					end else begin
						r_next.data_byte = rx;
						r_next.data_valid = 1'b1;
						if (r_reg.cmd == `SFSPI_OP_WRITE_STATUS_CMD) begin
							// lock bit only bites while the protect pin is low
							if (!(~s_wp_n & r_reg.lock)) begin
								r_next.lock = rx[`SFSPI_ST_LOCK]; // see RULE_12 // see RULE_19
								r_next.level = rx[`SFSPI_ST_LVL_HI:`SFSPI_ST_LVL_LO]; // see RULE_16
							end
							r_next.write_enable_flag = 1'b0; // see RULE_21
							r_next.cmd = 8'h00;
						end
					end
				end
			end
			if (sck_fall && r_reg.tx_on) begin
				r_next.so = r_reg.tx_sh[7]; // see RULE_01 // see RULE_22
				r_next.tx_sh = {r_reg.tx_sh[6:0], 1'b0};
				r_next.tx_cnt = r_reg.tx_cnt + 3'h1;
				// status read repeats with a fresh snapshot every eight bits
				if (r_reg.tx_cnt == `SFSPI_BYTE_LAST) begin
					r_next.tx_sh = st_now;
				end
			end
		end
		if (!r_next.tx_on && r_reg.ebsy && aai_mode) begin
			r_next.so = ~array_busy; // see RULE_18
		end
		if (!aai_mode && !array_busy) begin
			r_next.ebsy = 1'b0;
		end
		if (write_done) begin
			r_next.erase_kind = SFSPI_ER_NONE;
		end
		r_next.so_oe_n = s_cs_n | r_next.paused
			| ~(r_next.tx_on | (r_reg.ebsy & aai_mode)); // see RULE_08
		r_next.status = st_now & ~(wr_mask & 8'h00) | (st_now & wr_mask); // see RULE_15 // see RULE_20
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '0;
			r_reg.level <= `SFSPI_LVL_RESET; // see RULE_16
			r_reg.so_oe_n <= 1'b1;
			r_reg.status <= 8'h1c;
		end else begin
			r_reg <= r_next;
		end
	end

	// both clock idle levels are accepted: only edges matter, see RULE_02
	assign link.so = r_reg.so;
	assign link.so_oe_n = r_reg.so_oe_n;
	assign status_out = r_reg.status;
	assign cmd_byte = r_reg.cmd_byte;
	assign cmd_valid = r_reg.cmd_valid;
	assign data_byte = r_reg.data_byte;
	assign data_valid = r_reg.data_valid;
	assign erase_kind = r_reg.erase_kind;
endmodule

// *** rtl/sfspi_host.sv ***
// host-side controller: makes the serial clock and shifts bytes on command
`timescale 1ns/1ps
`include "sfspi_regs.svh"
module sfspi_host
	import sfspi_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	sfspi_if.host link,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata
);
	import sfspi_pkg::*;

	localparam logic [3:0] HALF_LAST = 4'(`SFSPI_HALF_CYC - 1);

	sfspi_host_t r_reg;
	sfspi_host_t r_next;
	logic so_s;
	logic mode3;

	sfspi_sync #(.W(1)) u_sync (
		.clk(clk),
		.rstn(rstn),
		.d(link.so_line),
		.init(1'b1),
		.q(so_s)
	);

	assign mode3 = r_reg.ctrl[`SFSPI_CTRL_MODE3];

	always_comb begin
		r_next = r_reg;
		r_next.rdata = 8'h00;
		r_next.div = r_reg.div + 4'h1;
		if (wr && addr == `SFSPI_ADR_CTRL) begin
			r_next.ctrl = wdata[3:0];
		end
		if (rd && addr == `SFSPI_ADR_CTRL) begin
			r_next.rdata = {4'h0, r_reg.ctrl};
		end else if (rd && addr == `SFSPI_ADR_RX) begin
			r_next.rdata = r_reg.rx;
			r_next.done = 1'b0;
		end else if (rd && addr == `SFSPI_ADR_STAT) begin
			r_next.rdata = {5'h00, ~r_reg.cs_n, r_reg.done, r_reg.st != SFSPI_H_IDLE};
		end
		case (r_reg.st)
			SFSPI_H_IDLE: begin
				r_next.sck = mode3; // see RULE_02
				if (!r_reg.ctrl[`SFSPI_CTRL_KEEP]) begin
					r_next.cs_n = 1'b1;
				end
				if (wr && addr == `SFSPI_ADR_TX) begin
					r_next.tx = wdata;
					r_next.cs_n = 1'b0; // see RULE_03
					r_next.st = SFSPI_H_LOW;
					r_next.div = 4'h0;
					r_next.bitn = 3'h0;
				end
			end
			SFSPI_H_LOW: begin
				r_next.sck = 1'b0;
				r_next.si = r_reg.tx[7]; // see RULE_22
				if (r_reg.div == HALF_LAST) begin
					r_next.st = SFSPI_H_HIGH;
					r_next.div = 4'h0;
				end
			end
			SFSPI_H_HIGH: begin
				r_next.sck = 1'b1; // see RULE_01
				if (r_reg.div == HALF_LAST) begin
					// late in the high phase the device output has long settled
					r_next.rx = {r_reg.rx[6:0], so_s};
					r_next.tx = {r_reg.tx[6:0], 1'b0};
					r_next.bitn = r_reg.bitn + 3'h1;
					r_next.div = 4'h0;
					r_next.st = SFSPI_H_LOW;
					if (r_reg.bitn == `SFSPI_BYTE_LAST) begin
						r_next.st = SFSPI_H_IDLE;
						r_next.done = 1'b1;
					end
				end
			end
			default: begin
				r_next.st = SFSPI_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '0;
			r_reg.ctrl <= `SFSPI_CTRL_RESET;
			r_reg.cs_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// pause follows the control bit alone, not gated by select; the bench keeps it asserted across a deselect, see RULE_04
	assign link.hold_n = ~r_reg.ctrl[`SFSPI_CTRL_HOLD];
	assign link.wp_n = r_reg.ctrl[`SFSPI_CTRL_WP];
	assign link.sck = r_reg.sck;
	assign link.cs_n = r_reg.cs_n;
	assign link.si = r_reg.si;
	assign rdata = r_reg.rdata;
endmodule

// *** testbench/sfspi_assertions.sv ***
// link checker for the serial flash front end
`timescale 1ns/1ps
module sfspi_assertions (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe_n,
	input wire logic hold_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// rises seen in the current frame, modulo one byte
	logic [2:0] rise_cnt_reg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rise_cnt_reg <= 3'h0;
		end else if (cs_n) begin
			rise_cnt_reg <= 3'h0;
		end else if ($rose(sck)) begin
			rise_cnt_reg <= rise_cnt_reg + 3'h1;
		end
	end
	// six samples cover the three-cycle lag of the device (two-flop synchroniser plus output register)
	property p_desel_float;
		cs_n [*6] |-> so_oe_n;
	endproperty
	a_desel_float: assert property (p_desel_float)
		else $error("output driven while deselected");
	property p_hold_float;
		(!cs_n && !hold_n && !sck) [*6] |-> so_oe_n;
	endproperty
	a_hold_float: assert property (p_hold_float)
		else $error("output driven while paused");
	property p_so_low;
		!so_oe_n && !$past(so_oe_n) && $changed(so) |-> !sck;
	endproperty
	a_so_low: assert property (p_so_low)
		else $error("output changed in clock high phase");
	property p_si_hold;
		$rose(sck) |=> $stable(si) [*3];
	endproperty
	a_si_hold: assert property (p_si_hold)
		else $error("input moved while clock high");
	property p_high4;
		$rose(sck) && !cs_n |=> sck [*3];
	endproperty
	a_high4: assert property (p_high4)
		else $error("clock high phase too short");
	property p_low4;
		$fell(sck) && !cs_n |=> !sck [*3];
	endproperty
	a_low4: assert property (p_low4)
		else $error("clock low phase too short");
	property p_fall_sel;
		$fell(sck) |-> !cs_n;
	endproperty
	a_fall_sel: assert property (p_fall_sel)
		else $error("clock fell while deselected");
	property p_byte8;
		$rose(cs_n) |-> rise_cnt_reg == 3'h0;
	endproperty
	a_byte8: assert property (p_byte8)
		else $error("frame not whole bytes");
endmodule

// *** testbench/serial_flash_spi_front_end_bench.sv ***
// self-checking bench: host controller drives the flash front end
`timescale 1ns/1ps
`include "sfspi_regs.svh"
module serial_flash_spi_front_end_bench;
	import sfspi_pkg::*;
	logic clk, rstn, wr, rd, ab, am, wd, cv, dv;
	logic [3:0] addr, ctrl;
	logic [7:0] wdata, rdata, st, cb, db, lc, rx, d;
	sfspi_erase_t ek;
	int mismatches, num_checks, lock, level, write_enable_flag, bsy, auto_increment_program, wp, i;
	logic [7:0] txq[$];
	sfspi_if link ();
	sfspi_host i_sfspi_host (.clk(clk), .rstn(rstn), .link(link), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	sfspi_device i_sfspi_device (.clk(clk), .rstn(rstn), .link(link), .array_busy(ab),
		.aai_mode(am), .write_done(wd), .status_out(st), .cmd_byte(cb), .cmd_valid(cv),
		.data_byte(db), .data_valid(dv), .erase_kind(ek));
	sfspi_assertions i_sfspi_assertions (.clk(clk), .rstn(rstn), .sck(link.sck),
		.cs_n(link.cs_n), .si(link.si), .so(link.so), .so_oe_n(link.so_oe_n),
		.hold_n(link.hold_n));
	always @(posedge clk) begin
		if (cv) begin
			lc <= cb;
		end
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [7:0] mst();
		return {lock[0], auto_increment_program[0], level[3:0], write_enable_flag[0], bsy[0]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// one byte on the link; busy is polled with a bound
	task automatic xf(input logic [7:0] b);
		logic [7:0] s;
		int n;
		wreg(`SFSPI_ADR_TX, b);
		s = 8'h01;
		for (n = 0; n < 200 && s[0]; n++) begin
			rreg(`SFSPI_ADR_STAT, s);
		end
		chk({7'h0, s[0]}, 8'h00);
		rreg(`SFSPI_ADR_RX, rx);
	endtask
	// whole frame: select held over every queued byte
	task automatic fr();
		wreg(`SFSPI_ADR_CTRL, {4'h0, ctrl | 4'h8});
		while (txq.size() > 0) begin
			xf(txq.pop_front());
		end
		wreg(`SFSPI_ADR_CTRL, {4'h0, ctrl & 4'h7});
		repeat (12) @(posedge clk);
	endtask
	task automatic stc();
		txq = {`SFSPI_OP_RDSR, 8'h00};
		fr();
		chk(rx, mst());
		chk(st, mst());
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		mismatches++;
		print_verdict();
	end
	initial begin
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		ab = 1'b0;
		am = 1'b0;
		wd = 1'b0;
		ctrl = 4'h4;
		level = 7;
		void'($urandom(32'h637c3db8));
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		chk(st, mst());
		stc();
		txq = {`SFSPI_OP_WREN};
		fr();
		write_enable_flag = 1;
		chk(lc, `SFSPI_OP_WREN);
		stc();
		$display("test reset and enable done");
		for (i = 0; i < 6; i++) begin
			d = 8'($urandom);
			wp = (i == 1) ? 0 : (i < 3) ? 1 : $urandom % 2;
			if (i == 0) begin
				d[7] = 1'b1;
			end
			ctrl[2] = wp[0];
			txq = {`SFSPI_OP_WRITE_STATUS_CMD, d};
			fr();
			if (wp != 0 || lock == 0) begin
				lock = d[7];
				level = d[5:2];
			end
			write_enable_flag = 0;
			stc();
		end
		$display("test status write done");
		for (i = 1; i < 4; i++) begin
			d = (i == 1) ? `SFSPI_OP_SE4K : (i == 2) ? `SFSPI_OP_BE32K : `SFSPI_OP_BE64K;
			txq = {`SFSPI_OP_WREN, d};
			fr();
			txq = {d, 8'($urandom), 8'h00, 8'h00};
			fr();
			chk(8'(ek), 8'(i));
			@(posedge clk);
			wd <= 1'b1;
			@(posedge clk);
			wd <= 1'b0;
			write_enable_flag = 0;
			stc();
			chk(8'(ek), 8'h00);
		end
		$display("test erase done");
		@(posedge clk);
		ab <= 1'b1;
		am <= 1'b1;
		bsy = 1;
		auto_increment_program = 1;
		txq = {`SFSPI_OP_WREN};
		fr();
		stc();
		@(posedge clk);
		ab <= 1'b0;
		am <= 1'b0;
		bsy = 0;
		auto_increment_program = 0;
		$display("test busy done");
		wreg(`SFSPI_ADR_CTRL, {4'h0, ctrl | 4'h8});
		xf(`SFSPI_OP_RDSR);
		wreg(`SFSPI_ADR_CTRL, {4'h0, ctrl | 4'ha});
		repeat (20) @(posedge clk);
		chk({7'h0, link.so_oe_n}, 8'h01);
		wreg(`SFSPI_ADR_CTRL, {4'h0, ctrl | 4'h8});
		xf(8'h00);
		chk(rx, mst());
		wreg(`SFSPI_ADR_CTRL, {4'h0, ctrl | 4'ha});
		repeat (10) @(posedge clk);
		wreg(`SFSPI_ADR_CTRL, {4'h0, ctrl | 4'h2});
		repeat (10) @(posedge clk);
		chk({7'h0, link.so_line}, 8'h01);
		wreg(`SFSPI_ADR_CTRL, {4'h0, ctrl});
		repeat (10) @(posedge clk);
		stc();
		$display("test hold done");
		ctrl[0] = 1'b1;
		wreg(`SFSPI_ADR_CTRL, {4'h0, ctrl});
		repeat (8) @(posedge clk);
		stc();
		txq = {`SFSPI_OP_WREN};
		fr();
		write_enable_flag = 1;
		stc();
		txq = {`SFSPI_OP_WRDI};
		fr();
		write_enable_flag = 0;
		stc();
		$display("test mode three done");
		print_verdict();
	end
endmodule
